// [rtl/drd_decode.sv]
// Dual bus ram address decode, strap config and interrupt routing
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "drd_regs.svh"
module drd_decode (
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System bus address and strobe
  input wire logic [23:0] sysAddr,
  input wire logic sysMemReq,
  input wire logic [15:0] sysIoAddr,
  input wire logic sysIoReq,
  // Local extension bus upper address and strobe
  input wire logic [7:0] localAddrHigh,
  input wire logic localAddrStrobe,
  // Power supply protect, async pin
  input wire logic memory_protect_n,
  // ECC event pulses per bus
  input wire logic sysEccEvent,
  input wire logic localEccEvent,
  // Decode outputs
  output logic sysMemHit,
  output logic [7:0] sysBlockOffset,
  output logic localMemHit,
  output logic ioPortHit,
  output logic localSlowMode,
  output logic [7:0] intLevel,
  output logic indicatorLed
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [31:0] cfg_r; // Strap image, software set
  logic [31:0] eccCtl_r; // ECC control status register storage
  logic [31:0] eccErr_r; // ECC error status register storage
  logic [31:0] route_r; // Interrupt routing
  logic sysIrq_r; // Sticky system bus ECC interrupt
  logic localIrq_r; // Sticky local bus ECC interrupt
  logic [31:0] prdata_r;
  drd_pkg::drd_phase_t phase_r;
  // Filtered protect level, low means memory protected
  logic protectN;
  drd_sync uProtSync (
    .mclk(mclk),
    .reset(reset),
    .din(memory_protect_n),
    .dout(protectN)
  );
  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [7:0] sysBase = cfg_r[`DRD_CFG_BASE_MSB:`DRD_CFG_BASE_LSB];
  wire [1:0] pageSel = cfg_r[`DRD_CFG_PAGE_MSB:`DRD_CFG_PAGE_LSB];
  wire drd_pkg::drd_cap_t capSel = drd_pkg::drd_cap_t'(cfg_r[`DRD_CFG_CAP_MSB:`DRD_CFG_CAP_LSB]);
  wire [2:0] localPos = cfg_r[`DRD_CFG_LBASE_MSB:`DRD_CFG_LBASE_LSB];
  wire drd_pkg::drd_range_t rangeSel = drd_pkg::drd_range_t'(cfg_r[`DRD_CFG_RANGE_MSB:`DRD_CFG_RANGE_LSB]);
  wire [1:0] ioCol = cfg_r[`DRD_CFG_IOCOL_MSB:`DRD_CFG_IOCOL_LSB];
  wire [1:0] ioRow = cfg_r[`DRD_CFG_IOROW_MSB:`DRD_CFG_IOROW_LSB];
  wire sysOnly = cfg_r[`DRD_CFG_SYSONLY];
  // System window length in 16 KB blocks
  function automatic logic [8:0] sysBlocks(input drd_pkg::drd_cap_t c);
    case (c)
      drd_pkg::DRD_CAP_SMALL: sysBlocks = `DRD_BLK_SMALL;
      drd_pkg::DRD_CAP_MID: sysBlocks = `DRD_BLK_MID;
      default: sysBlocks = `DRD_BLK_LARGE;
    endcase
  endfunction : sysBlocks
  // Local window length in 64 KB blocks; doubles as base step
  function automatic logic [7:0] localBlocks(input drd_pkg::drd_cap_t c);
    case (c)
      drd_pkg::DRD_CAP_SMALL: localBlocks = `DRD_LBLK_SMALL;
      drd_pkg::DRD_CAP_MID: localBlocks = `DRD_LBLK_MID;
      default: localBlocks = `DRD_LBLK_LARGE;
    endcase
  endfunction : localBlocks
  // ----------------------------------------
  // System bus memory decode
  // ----------------------------------------
  wire [1:0] sysPage = sysAddr[23:22];
  wire [7:0] sysBlk = sysAddr[21:14];
  wire [8:0] blkDiff = {1'b0, sysBlk} - {1'b0, sysBase};
  wire pageMatch = (sysPage == pageSel);
  // Below base gives a negative difference, so no hit and no wrap
  wire sysInWindow = (sysBlk >= sysBase) && (blkDiff < sysBlocks(capSel));
  wire memAllowed = protectN;
  assign sysMemHit = sysMemReq && pageMatch && sysInWindow && memAllowed;
  assign sysBlockOffset = blkDiff[7:0];
  // ----------------------------------------
  // Local bus memory decode
  // ----------------------------------------
  // Base in 64 KB blocks: range offset plus position times step; range W uses the position alone
  wire [7:0] lStep = localBlocks(capSel);
  wire [7:0] posMul = 8'(lStep * {5'h00, localPos});
  wire [7:0] rngMul = 8'(lStep * `DRD_RANGE_STEP);
  // W range exists only on the large build (eight extra bases)
  wire rangeWOk = (capSel == drd_pkg::DRD_CAP_LARGE);
  logic [7:0] localBase;
  always_comb begin
    case (rangeSel)
      drd_pkg::DRD_RNG_X: localBase = posMul;
      drd_pkg::DRD_RNG_Y: localBase = 8'(posMul + (rngMul >> 1));
      drd_pkg::DRD_RNG_Z: localBase = 8'(posMul + rngMul);
      drd_pkg::DRD_RNG_W: localBase = 8'({5'h00, localPos} * `DRD_RANGE_W_STEP);
      default: localBase = posMul;
    endcase
  end
  wire [8:0] lDiff = {1'b0, localAddrHigh} - {1'b0, localBase};
  wire localInWindow = (localAddrHigh >= localBase) && (lDiff < {1'b0, lStep});
  wire localRangeOk = (rangeSel != drd_pkg::DRD_RNG_W) || rangeWOk;
  assign localMemHit = localAddrStrobe && !sysOnly && localInWindow && localRangeOk && memAllowed;
  assign localSlowMode = cfg_r[`DRD_CFG_SLOW];
  // ----------------------------------------
  // I/O port decode
  // ----------------------------------------
  // Top digit from lines F..C: 0,4,8,C; low digit 0 or 1
  wire [3:0] ioTop = {ioRow, 2'b00};
  wire [15:0] ioMatch = {ioTop, `DRD_IO_LOW, ioCol[0]};
  wire ioUserCol = ioCol[1]; // Column reserved for reprogrammed logic
  assign ioPortHit = sysIoReq && !ioUserCol && (sysIoAddr == ioMatch);
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire apbAccess = psel && penable && (phase_r == drd_pkg::DRD_PH_IDLE);
  // Writes land only at the edge where the master sees ready
  wire apbWr = psel && penable && pready && pwrite;
  wire apbRd = apbAccess && !pwrite;
  wire selCfg = (paddr == `DRD_OFF_CONFIG);
  wire selSts = (paddr == `DRD_OFF_STATUS);
  wire selCtl = (paddr == `DRD_OFF_ECCCTL);
  wire selErr = (paddr == `DRD_OFF_ECCERR);
  wire selRte = (paddr == `DRD_OFF_IRQRTE);
  wire selAny = selCfg || selSts || selCtl || selErr || selRte;
  // Status word shows live interrupt and protect state
  wire [31:0] statusWord = {28'h0000000, !protectN, indicatorLed, localIrq_r, sysIrq_r};
  wire [31:0] rdMux = selCfg ? cfg_r :
                      selSts ? statusWord :
                      selCtl ? eccCtl_r :
                      selErr ? eccErr_r :
                      selRte ? route_r : `DRD_ZERO32;
  // One wait state: answer in the cycle after the first access cycle
  assign pready = (phase_r == drd_pkg::DRD_PH_DONE);
  assign pslverr = pready && !selAny;
  assign prdata = prdata_r;
  // Phase tracker for the APB wait state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phase_r <= drd_pkg::DRD_PH_IDLE;
    end else if (apbAccess) begin
      phase_r <= drd_pkg::DRD_PH_DONE;
    end else begin
      phase_r <= drd_pkg::DRD_PH_IDLE;
    end
  end
  // Read data capture
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata_r <= `DRD_ZERO32;
    end else if (apbRd) begin
      prdata_r <= rdMux;
    end
  end
  // Config, control and routing writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_r <= `DRD_CFG_RESET;
      eccCtl_r <= `DRD_ZERO32;
      eccErr_r <= `DRD_ZERO32;
      route_r <= `DRD_RTE_RESET;
    end else if (apbWr) begin
      if (selCfg) begin
        cfg_r <= pwdata;
      end
      if (selCtl) begin
        eccCtl_r <= pwdata;
      end
      if (selErr) begin
        eccErr_r <= pwdata;
      end
      if (selRte) begin
        route_r <= pwdata;
      end
    end
  end
  // ----------------------------------------
  // Interrupt flags and routing
  // ----------------------------------------
  // Write one to the two interrupt status bits clears; a new event wins over the clear
  wire clrSys = apbWr && selSts && pwdata[0];
  wire clrLoc = apbWr && selSts && pwdata[1];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sysIrq_r <= 1'b0;
      localIrq_r <= 1'b0;
    end else begin
      sysIrq_r <= sysEccEvent || (sysIrq_r && !clrSys);
      localIrq_r <= localEccEvent || (localIrq_r && !clrLoc);
    end
  end
  wire [2:0] sysLvl = route_r[`DRD_RTE_SYS_MSB-1:`DRD_RTE_SYS_LSB];
  wire sysEn = route_r[`DRD_RTE_SYS_LSB+`DRD_RTE_EN];
  wire [2:0] locLvl = route_r[`DRD_RTE_LOC_MSB-1:`DRD_RTE_LOC_LSB];
  wire locEn = route_r[`DRD_RTE_LOC_LSB+`DRD_RTE_EN];
  // Each level line ORs both sources; same level loses bus identity
  genvar gi;
  generate
    for (gi = 0; gi < `DRD_LVL_COUNT; gi = gi + 1) begin : gLevel
      assign intLevel[gi] = (sysIrq_r && sysEn && (sysLvl == gi)) ||
                            (localIrq_r && locEn && (locLvl == gi));
    end
  endgenerate
  // Lamp follows any pending interrupt, routed or not
  assign indicatorLed = sysIrq_r || localIrq_r;
endmodule : drd_decode

// [rtl/drd_regs.svh]
// Constants for the dual bus ram address decode block
`ifndef DRD_REGS_SVH
`define DRD_REGS_SVH
// ----------------------------------------
// Register bus map
// ----------------------------------------
`define DRD_OFF_CONFIG 12'h000
`define DRD_OFF_STATUS 12'h004
`define DRD_OFF_ECCCTL 12'h008
`define DRD_OFF_ECCERR 12'h00C
`define DRD_OFF_IRQRTE 12'h010
// ----------------------------------------
// Config register fields
// ----------------------------------------
`define DRD_CFG_BASE_LSB 0
`define DRD_CFG_BASE_MSB 7
`define DRD_CFG_PAGE_LSB 8
`define DRD_CFG_PAGE_MSB 9
`define DRD_CFG_CAP_LSB 10
`define DRD_CFG_CAP_MSB 11
`define DRD_CFG_LBASE_LSB 12
`define DRD_CFG_LBASE_MSB 14
`define DRD_CFG_RANGE_LSB 16
`define DRD_CFG_RANGE_MSB 17
`define DRD_CFG_IOCOL_LSB 20
`define DRD_CFG_IOCOL_MSB 21
`define DRD_CFG_IOROW_LSB 22
`define DRD_CFG_IOROW_MSB 23
`define DRD_CFG_SYSONLY 24
`define DRD_CFG_SLOW 25
// Default: base 0, page 0, small build, local base 0, range X, I/O 01C0, fast
`define DRD_CFG_RESET 32'h0000_0000
// ----------------------------------------
// Interrupt routing fields
// ----------------------------------------
`define DRD_RTE_SYS_LSB 0
`define DRD_RTE_SYS_MSB 3
`define DRD_RTE_LOC_LSB 4
`define DRD_RTE_LOC_MSB 7
// Sys level 5 enabled, local unconnected
`define DRD_RTE_RESET 32'h0000_000D
`define DRD_RTE_EN 3
// ----------------------------------------
// Decode figures
// ----------------------------------------
`define DRD_BLK_SMALL 9'h008
`define DRD_BLK_MID 9'h010
`define DRD_BLK_LARGE 9'h020
`define DRD_LBLK_SMALL 8'h02
`define DRD_LBLK_MID 8'h04
`define DRD_LBLK_LARGE 8'h08
`define DRD_RANGE_STEP 8'h0E
`define DRD_RANGE_W_STEP 8'h01
// Port address bits 11:1 (digits 1C0 without the lowest bit)
`define DRD_IO_LOW 11'h0E0
`define DRD_LVL_COUNT 8
`define DRD_ZERO32 32'h0000_0000
`endif

// [rtl/drd_pkg.sv]
// Types for the dual bus ram address decode block
package drd_pkg;
  // Board capacity builds
  typedef enum logic [1:0] {
    DRD_CAP_SMALL = 2'b00,
    DRD_CAP_MID = 2'b01,
    DRD_CAP_LARGE = 2'b10,
    DRD_CAP_RSVD = 2'b11
  } drd_cap_t;
  // Local range select positions
  typedef enum logic [1:0] {
    DRD_RNG_X = 2'b00,
    DRD_RNG_Y = 2'b01,
    DRD_RNG_Z = 2'b10,
    DRD_RNG_W = 2'b11
  } drd_range_t;
  // Bus slave phase
  typedef enum logic [0:0] {
    DRD_PH_IDLE = 1'b0,
    DRD_PH_DONE = 1'b1
  } drd_phase_t;
endpackage : drd_pkg

// [rtl/drd_sync.sv]
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module drd_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  // Stage flops; stage one is read only by stage two
  logic s1R;
  logic s2R;
  logic s3R;
  logic dout_r;
  // Shift chain plus filtered output
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1R <= 1'b0;
      s2R <= 1'b0;
      s3R <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      s1R <= din;
      s2R <= s1R;
      s3R <= s2R;
      // Change counts once stages two and three agree
      if (s2R == s3R) begin
        dout_r <= s3R;
      end
    end
  end
  assign dout = dout_r;
endmodule : drd_sync

// [tb/drd_decode_checker.sv]
// Concurrent property checker for the decode block
`timescale 1ns/100ps
module drd_decode_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sysMemReq,
  input wire logic sysMemHit,
  input wire logic [7:0] sysBlockOffset,
  input wire logic localAddrStrobe,
  input wire logic localMemHit,
  input wire logic [15:0] sysIoAddr,
  input wire logic sysIoReq,
  input wire logic ioPortHit,
  input wire logic memory_protect_n,
  input wire logic sysEccEvent,
  input wire logic [7:0] intLevel,
  input wire logic indicatorLed
);
  // ----------------------------------------
  // Properties, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("slave answer missed its single wait state");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_sys_hit_req: assert property (sysMemHit |-> sysMemReq)
    else $error("system hit without request");
  a_offset_in_window: assert property (sysMemHit |-> sysBlockOffset < 8'h20)
    else $error("block offset beyond largest window");
  a_local_needs_strobe: assert property (localMemHit |-> localAddrStrobe)
    else $error("local hit without strobe");
  a_io_low_digits: assert property (ioPortHit |-> sysIoReq && sysIoAddr[11:1] == 11'h0E0)
    else $error("port hit on wrong low digits");
  // Sync latency is four edges, so six lows leave margin
  a_protect_blocks: assert property (!memory_protect_n [*6] |-> !sysMemHit && !localMemHit)
    else $error("memory hit while protected");
  a_event_lights_led: assert property (sysEccEvent |=> indicatorLed)
    else $error("indicator dark after event");
  a_level_lights_led: assert property (|intLevel |-> indicatorLed)
    else $error("level active with indicator dark");
endmodule : drd_decode_checker
bind drd_decode drd_decode_checker chk_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sysMemReq(sysMemReq), .sysMemHit(sysMemHit),
  .sysBlockOffset(sysBlockOffset), .localAddrStrobe(localAddrStrobe), .localMemHit(localMemHit),
  .sysIoAddr(sysIoAddr), .sysIoReq(sysIoReq), .ioPortHit(ioPortHit), .memory_protect_n(memory_protect_n),
  .sysEccEvent(sysEccEvent), .intLevel(intLevel), .indicatorLed(indicatorLed));

// [tb/drd_host_model.sv]
// Processor board model driving both address buses
`timescale 1ns/100ps
module drd_host_model (
  input wire logic mclk,
  output logic [23:0] sysAddr,
  output logic sysMemReq,
  output logic [15:0] sysIoAddr,
  output logic sysIoReq,
  output logic [7:0] localAddrHigh,
  output logic localAddrStrobe
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    sysAddr = 24'h000000;
    sysMemReq = 1'b0;
    sysIoAddr = 16'h0000;
    sysIoReq = 1'b0;
    localAddrHigh = 8'h00;
    localAddrStrobe = 1'b0;
  end
  // Both buses strobed in the same cycle, each with its own address
  task automatic memCycle(input logic [23:0] a, input logic [7:0] l);
    @(posedge mclk);
    sysAddr <= a;
    sysMemReq <= 1'b1;
    localAddrHigh <= l;
    localAddrStrobe <= 1'b1;
  endtask : memCycle
  task automatic ioCycle(input logic [15:0] a);
    @(posedge mclk);
    sysIoAddr <= a;
    sysIoReq <= 1'b1;
  endtask : ioCycle
  // Released lines invert, so stale data never looks valid
  task automatic idleBus;
    @(posedge mclk);
    sysMemReq <= 1'b0;
    localAddrStrobe <= 1'b0;
    sysIoReq <= 1'b0;
    sysAddr <= ~sysAddr;
    localAddrHigh <= ~localAddrHigh;
    sysIoAddr <= ~sysIoAddr;
  endtask : idleBus
endmodule : drd_host_model

// [tb/test_dual_bus_ram_address_decode.sv]
// Self-checking bench for the decode block
`timescale 1ns/100ps
`include "drd_regs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failCount++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_dual_bus_ram_address_decode;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, memory_protect_n = 1'b1, sysEv = 1'b0, locEv = 1'b0;
  logic [23:0] sysAddr;
  logic [15:0] ioA, eA;
  logic sysReq, ioReq, lStb, sysHit, locHit, ioHit, slowMode, led;
  logic [7:0] lAddr, blkOff, intLevel, b, lb;
  logic [8:0] t;
  logic [33:0] x;
  logic [33:0] expQ[$];
  int checks = 0, failCount = 0, seed = 20552, n, st, k;
  always #10 mclk = ~mclk;
  drd_decode dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysAddr(sysAddr), .sysMemReq(sysReq), .sysIoAddr(ioA), .sysIoReq(ioReq), .localAddrHigh(lAddr),
    .localAddrStrobe(lStb), .memory_protect_n(memory_protect_n), .sysEccEvent(sysEv),
    .localEccEvent(locEv), .sysMemHit(sysHit), .sysBlockOffset(blkOff), .localMemHit(locHit),
    .ioPortHit(ioHit), .localSlowMode(slowMode), .intLevel(intLevel), .indicatorLed(led));
  drd_host_model hostU (.mclk(mclk), .sysAddr(sysAddr), .sysMemReq(sysReq), .sysIoAddr(ioA),
    .sysIoReq(ioReq), .localAddrHigh(lAddr), .localAddrStrobe(lStb));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // One APB transfer; the watcher checks the answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    i = 0;
    expQ.push_back({w, e});
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin @(posedge mclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin failCount++; test_done(); end
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask : apb
  task automatic pulse(input logic s, input logic l);
    @(posedge mclk);
    sysEv <= s;
    locEv <= l;
    @(posedge mclk);
    sysEv <= 1'b0;
    locEv <= 1'b0;
    @(negedge mclk);
  endtask : pulse
  // Oldest note against each answer
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      x = expQ.pop_front();
      if (!x[33]) `CHK("prdata", x[31:0], prdata)
      `CHK("pslverr", x[32], pslverr)
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    apb(0, `DRD_OFF_CONFIG, 0, 33'h0);
    apb(0, `DRD_OFF_IRQRTE, 0, 33'h0D);
    apb(0, 12'h014, 0, 33'h1_0000_0000);
    apb(1, 12'h018, 32'hFFFF_FFFF, 33'h1_0000_0000);
    `CHK("slow", 1'b0, slowMode)
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      b = (c == 3) ? 8'hFF : (c == 2) ? 8'hF0 : 8'($random(seed));
      n = (c == 0) ? 8 : (c == 1) ? 16 : 32;
      apb(1, `DRD_OFF_CONFIG, {20'h0, 2'(c), 2'b01, b}, 33'h0);
      for (int j = 0; j < 3; j++) begin
        k = (j == 0) ? 0 : n - 2 + j;
        t = {1'b0, b} + 9'(k);
        hostU.memCycle({2'b01, t[7:0], 14'h0}, 8'h00);
        @(negedge mclk);
        `CHK("sysHit", (k < n && t < 9'h100), sysHit)
        if (k < n && t < 9'h100) `CHK("offset", 8'(k), blkOff)
      end
      hostU.memCycle({2'b00, b, 14'h0}, 8'h00);
      @(negedge mclk);
      `CHK("pageMiss", 1'b0, sysHit)
    end
    $display("test system window done");
    for (int c = 0; c < 3; c++) for (int r = 0; r < 4; r++) for (int p = 0; p < 7; p++) begin
      st = 2 << c;
      lb = (r == 3) ? 8'(p) : 8'((p + 7 * r) * st);
      apb(1, `DRD_OFF_CONFIG, {14'h0, 2'(r), 1'b0, 3'(p), 2'(c), 10'h000}, 33'h0);
      for (int j = 0; j < 3; j++) begin
        k = (j == 0) ? 0 : st - 2 + j;
        hostU.memCycle(24'h0, lb + 8'(k));
        @(negedge mclk);
        `CHK("locHit", (k < st && (r != 3 || c == 2)), locHit)
      end
    end
    apb(1, `DRD_OFF_CONFIG, 32'h0300_0000, 33'h0);
    hostU.memCycle(24'h0, 8'h00);
    @(negedge mclk);
    `CHK("sysOnly", 1'b0, locHit)
    `CHK("slow", 1'b1, slowMode)
    $display("test local window done");
    for (int r = 0; r < 4; r++) for (int c = 0; c < 3; c++) begin
      apb(1, `DRD_OFF_CONFIG, {8'h0, 2'(r), 2'(c), 20'h0}, 33'h0);
      eA = {2'(r), 2'b00, 11'h0E0, c[0]};
      for (int j = 0; j < 3; j++) begin
        hostU.ioCycle((j == 0) ? eA : (j == 1) ? eA ^ 16'h1000 : eA ^ 16'h0001);
        @(negedge mclk);
        `CHK("ioHit", (j == 0 && c < 2), ioHit)
      end
    end
    hostU.idleBus();
    $display("test port decode done");
    pulse(1, 0);
    `CHK("intLevel", 8'h20, intLevel)
    apb(0, `DRD_OFF_STATUS, 0, 33'h5);
    apb(1, `DRD_OFF_STATUS, 32'h1, 33'h0);
    `CHK("led", 1'b0, led)
    apb(1, `DRD_OFF_IRQRTE, 32'hEC, 33'h0);
    pulse(0, 1);
    `CHK("intLevel", 8'h40, intLevel)
    pulse(1, 0);
    `CHK("intLevel", 8'h50, intLevel)
    apb(1, `DRD_OFF_STATUS, 32'h3, 33'h0);
    `CHK("intLevel", 8'h00, intLevel)
    $display("test interrupts done");
    apb(1, `DRD_OFF_CONFIG, 32'h0, 33'h0);
    @(posedge mclk);
    memory_protect_n <= 1'b0;
    repeat (6) @(posedge mclk);
    hostU.memCycle(24'h0, 8'h00);
    @(negedge mclk);
    `CHK("protSys", 1'b0, sysHit)
    `CHK("protLoc", 1'b0, locHit)
    apb(0, `DRD_OFF_STATUS, 0, 33'h8);
    @(posedge mclk);
    memory_protect_n <= 1'b1;
    repeat (6) @(posedge mclk);
    hostU.memCycle(24'h0, 8'h00);
    @(negedge mclk);
    `CHK("unprot", 1'b1, sysHit)
    $display("test protect done");
    test_done();
  end
endmodule : test_dual_bus_ram_address_decode
